// file: hdl/adc_seq_pkg.sv
package adc_seq_pkg;

    localparam int CHAN_W      = 5;
    localparam int REF_W       = 2;
    localparam int RES_W       = 10;
    localparam int SRC_W       = 3;
    localparam int SRC_COUNT   = 8;
    localparam int CNT_W       = 5;
    localparam int PRE_SEL_W   = 3;
    localparam int PRE_CNT_W   = 8;
    localparam int SYNC_CYCLES = 3;

    // Converter clock cycle counts
    localparam logic [CNT_W-1:0] NORMAL_CYCLES   = 5'h0D;
    localparam logic [CNT_W-1:0] FIRST_CYCLES    = 5'h19;
    localparam logic [CNT_W-1:0] SH_NORMAL_WHOLE = 5'h03;
    localparam logic [CNT_W-1:0] SH_FIRST_WHOLE  = 5'h0D;
    localparam logic [CNT_W-1:0] SH_AUTO_CYCLES  = 5'h02;
    localparam logic [CNT_W-1:0] CNT_ONE         = 5'h01;

    // Trigger source code that selects free running
    localparam logic [SRC_W-1:0] SRC_DONE_FLAG = 3'h0;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_ARMED   = 2'b01,
        ST_CONVERT = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic [CHAN_W-1:0] channel;
        logic [REF_W-1:0]  reference;
    } selection_s;

    typedef struct packed {
        seq_state_e       state;
        logic [CNT_W-1:0] cycleCount;
        logic             firstConv;
        logic             autoStart;
        logic             startBit;
        logic             doneFlag;
        logic [RES_W-1:0] result;
        selection_s       liveSel;
        logic             sampleHold;
        logic             wake;
        logic             haltedPrev;
    } seq_regs_s;

    localparam seq_regs_s SEQ_RESET = '{
        state:      ST_IDLE,
        cycleCount: 5'h00,
        firstConv:  1'b1,
        autoStart:  1'b0,
        startBit:   1'b0,
        doneFlag:   1'b0,
        result:     10'h000,
        liveSel:    '{channel: 5'h00, reference: 2'h0},
        sampleHold: 1'b0,
        wake:       1'b0,
        haltedPrev: 1'b0
    };

    typedef struct packed {
        logic                   prevLevel;
        logic [SYNC_CYCLES-1:0] pipe;
    } trig_regs_s;

endpackage

// file: hdl/adc_prescaler.sv
module adc_prescaler #(
    parameter int SEL_W = adc_seq_pkg::PRE_SEL_W,
    parameter int CNT_W = adc_seq_pkg::PRE_CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clkEn,
    input  wire logic             enable,
    input  wire logic             restart,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  riseTick,
    output logic                  fallTick
);

    if (CNT_W < (1 << SEL_W)) begin : g_check
        $error("Prescaler counter too narrow for the largest ratio");
    end

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic [CNT_W:0]   divisor;

    // Division ratio is two to the power sel plus one
    function automatic logic [CNT_W:0] ratio(input logic [SEL_W-1:0] s);
        ratio = (CNT_W+1)'(2) << s;
    endfunction

    always_comb begin
        divisor  = ratio(sel);
        riseTick = enable && !restart && (count_reg == CNT_W'(divisor - 1'b1));
        fallTick = enable && !restart && (count_reg == CNT_W'((divisor >> 1) - 1'b1));
        if (!enable || restart || riseTick) begin
            count_next = '0;
        end else begin
            count_next = CNT_W'(count_reg + 1'b1);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= '0;
        end else if (clkEn) begin
            count_reg <= count_next;
        end
    end

endmodule // adc_prescaler

// file: hdl/adc_trigger_edge.sv
module adc_trigger_edge #(
    parameter int SRC_COUNT = adc_seq_pkg::SRC_COUNT
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          clkEn,
    input  wire logic                          armed,
    input  wire logic [SRC_COUNT-1:0]          sources,
    input  wire logic [adc_seq_pkg::SRC_W-1:0] sel,
    output logic                               trigPulse
);

    if (SRC_COUNT > (1 << adc_seq_pkg::SRC_W) || SRC_COUNT < 2) begin : g_check
        $error("Trigger source count does not fit the select width");
    end

    adc_seq_pkg::trig_regs_s state_reg;
    adc_seq_pkg::trig_regs_s state_next;
    logic                    level;
    logic                    edgeSeen;

    always_comb begin
        level      = (32'(sel) < SRC_COUNT) ? sources[sel] : 1'b0;
        // Only a fresh rising edge counts; a level held high is ignored
        edgeSeen   = armed && (sel != adc_seq_pkg::SRC_DONE_FLAG)
                     && level && !state_reg.prevLevel;
        state_next.prevLevel = level;
        // Synchroniser delay of the trigger path
        state_next.pipe = {state_reg.pipe[adc_seq_pkg::SYNC_CYCLES-2:0], edgeSeen};
        trigPulse  = state_reg.pipe[adc_seq_pkg::SYNC_CYCLES-1];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= '0;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

endmodule // adc_trigger_edge

// file: hdl/adc_conversion_sequencer.sv
// Summary of operation
// - Start bit write runs one conversion, self-clears unless free running
// - Channel change waits for current conversion end
// - Selected trigger edge resets prescaler, starts conversion
// - Edges ignored while busy; held level never retriggers
// - Software clears source flag before next trigger
// - Done-flag source restarts after each completion
// - Amplified channels clear start bit, no free run
// - Start write works in auto mode; bit reads busy
// - Prescaler runs while enabled, held reset otherwise
// - Start write begins at next converter clock edge
// - Conversion lasts 13 cycles, first one 25
// - Sample-hold at 3.5 or 13.5 cycles
// - Completion stores result, sets done, clears start unless free running
// - Triggered sample-hold two cycles after edge, plus sync
// - Free running restarts at once, start bit high
// - Selection buffered, frozen during conversion until last cycle
// - Free-run channel change hits the conversion after next
// - Sleep entry starts conversion, completion wakes core
module adc_conversion_sequencer #(
    parameter int SRC_COUNT = adc_seq_pkg::SRC_COUNT
) (
    input  wire logic                               clk,
    input  wire logic                               rst,
    input  wire logic                               clkEn,
    input  wire logic                               converterEnable,
    input  wire logic                               startWrite,
    input  wire logic                               autoTriggerEnable,
    input  wire logic [adc_seq_pkg::SRC_W-1:0]      triggerSourceSelect,
    input  wire logic [SRC_COUNT-1:0]               triggerSources,
    input  wire logic                               doneFlagClear,
    input  wire logic [adc_seq_pkg::PRE_SEL_W-1:0]  clockPrescaleSelect,
    input  wire logic [adc_seq_pkg::CHAN_W-1:0]     channelSelectBits,
    input  wire logic [adc_seq_pkg::REF_W-1:0]      referenceSelectBits,
    input  wire logic                               amplifiedChannel,
    input  wire logic                               cpuHalted,
    input  wire logic [adc_seq_pkg::RES_W-1:0]      sarResult,
    output logic                                    conversionStartBit,
    output logic                                    conversionDoneFlag,
    output logic [adc_seq_pkg::RES_W-1:0]           resultData,
    output logic [adc_seq_pkg::CHAN_W-1:0]          liveChannel,
    output logic [adc_seq_pkg::REF_W-1:0]           liveReference,
    output logic                                    sampleHold,
    output logic                                    wakeRequest
);

    adc_seq_pkg::seq_regs_s state_reg;
    adc_seq_pkg::seq_regs_s state_next;

    logic                          riseTick;
    logic                          fallTick;
    logic                          trigPulse;
    logic                          trigAccept;
    logic                          freeRun;
    logic                          sleepStart;
    logic                          lastCycle;
    logic                          shHit;
    logic                          complete;
    logic [adc_seq_pkg::CNT_W-1:0] convLen;

    adc_prescaler u_prescaler (
        .clk      (clk),
        .rst      (rst),
        .clkEn    (clkEn),
        .enable   (converterEnable),
        .restart  (trigAccept),
        .sel      (clockPrescaleSelect),
        .riseTick (riseTick),
        .fallTick (fallTick)
    );

    adc_trigger_edge #(
        .SRC_COUNT (SRC_COUNT)
    ) u_trigger (
        .clk       (clk),
        .rst       (rst),
        .clkEn     (clkEn),
        .armed     (autoTriggerEnable && converterEnable),
        .sources   (triggerSources),
        .sel       (triggerSourceSelect),
        .trigPulse (trigPulse)
    );

    always_comb begin
        state_next = state_reg;
        state_next.sampleHold = 1'b0;
        state_next.haltedPrev = cpuHalted;
        complete   = 1'b0;
        convLen    = state_reg.firstConv ? adc_seq_pkg::FIRST_CYCLES
                                         : adc_seq_pkg::NORMAL_CYCLES;
        lastCycle  = (state_reg.state == adc_seq_pkg::ST_CONVERT)
                     && (state_reg.cycleCount == convLen - adc_seq_pkg::CNT_ONE);
        freeRun    = autoTriggerEnable && !amplifiedChannel
                     && (triggerSourceSelect == adc_seq_pkg::SRC_DONE_FLAG);
        sleepStart = cpuHalted && !state_reg.haltedPrev && !autoTriggerEnable;
        trigAccept = converterEnable && trigPulse
                     && (state_reg.state != adc_seq_pkg::ST_CONVERT);
        if (state_reg.autoStart) begin
            shHit = riseTick && (state_reg.cycleCount
                                 == adc_seq_pkg::SH_AUTO_CYCLES - adc_seq_pkg::CNT_ONE);
        end else if (state_reg.firstConv) begin
            shHit = fallTick && (state_reg.cycleCount == adc_seq_pkg::SH_FIRST_WHOLE);
        end else begin
            shHit = fallTick && (state_reg.cycleCount == adc_seq_pkg::SH_NORMAL_WHOLE);
        end
        if (!cpuHalted) begin
            state_next.wake = 1'b0;
        end
        if (!converterEnable) begin
            state_next.state      = adc_seq_pkg::ST_IDLE;
            state_next.startBit   = 1'b0;
            state_next.firstConv  = 1'b1;
            state_next.autoStart  = 1'b0;
            state_next.cycleCount = '0;
        end else begin
            case (state_reg.state)
                adc_seq_pkg::ST_IDLE, adc_seq_pkg::ST_ARMED: begin
                    if (trigAccept) begin
                        state_next.state      = adc_seq_pkg::ST_CONVERT;
                        state_next.autoStart  = 1'b1;
                        state_next.startBit   = 1'b1;
                        state_next.cycleCount = '0;
                    end else if (state_reg.state == adc_seq_pkg::ST_ARMED) begin
                        if (riseTick) begin
                            state_next.state      = adc_seq_pkg::ST_CONVERT;
                            state_next.autoStart  = 1'b0;
                            state_next.cycleCount = '0;
                        end
                    end else if (startWrite || sleepStart) begin
                        state_next.state    = adc_seq_pkg::ST_ARMED;
                        state_next.startBit = 1'b1;
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (shHit) begin
                        state_next.sampleHold = 1'b1;
                    end
                    if (riseTick && lastCycle) begin
                        complete              = 1'b1;
                        state_next.result     = sarResult;
                        state_next.firstConv  = 1'b0;
                        state_next.autoStart  = 1'b0;
                        state_next.cycleCount = '0;
                        if (cpuHalted) begin
                            state_next.wake = 1'b1;
                        end
                        if (!freeRun) begin
                            state_next.state    = adc_seq_pkg::ST_IDLE;
                            state_next.startBit = 1'b0;
                        end
                    end else if (riseTick) begin
                        state_next.cycleCount =
                            adc_seq_pkg::CNT_W'(state_reg.cycleCount + 1'b1);
                    end
                end
                default: begin
                    state_next.state = adc_seq_pkg::ST_IDLE;
                end
            endcase
        end
        // Set wins over a simultaneous software clear
        state_next.doneFlag = (state_reg.doneFlag && !doneFlagClear) || complete;
        // Live selection follows the buffer except during a conversion before its last cycle
        if (state_reg.state != adc_seq_pkg::ST_CONVERT || lastCycle) begin
            state_next.liveSel = '{channel: channelSelectBits,
                                   reference: referenceSelectBits};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= adc_seq_pkg::SEQ_RESET;
        end else if (clkEn) begin
            state_reg <= state_next;
        end
    end

    assign conversionStartBit = state_reg.startBit;
    assign conversionDoneFlag = state_reg.doneFlag;
    assign resultData         = state_reg.result;
    assign liveChannel        = state_reg.liveSel.channel;
    assign liveReference      = state_reg.liveSel.reference;
    assign sampleHold         = state_reg.sampleHold;
    assign wakeRequest        = state_reg.wake;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_start_reads_busy: assert property (
        state_reg.state == adc_seq_pkg::ST_CONVERT |-> state_reg.startBit)
        else $error("Start bit low during conversion");

    a_done_on_complete: assert property (
        clkEn && complete |=> state_reg.doneFlag && state_reg.result == $past(sarResult))
        else $error("Completion did not store result and set done");

    a_single_clears_start: assert property (
        clkEn && complete && !freeRun |=> !state_reg.startBit
                                          && state_reg.state == adc_seq_pkg::ST_IDLE)
        else $error("Single conversion left start bit set");

    a_free_run_restart: assert property (
        clkEn && complete && freeRun |=> state_reg.startBit
                                         && state_reg.state == adc_seq_pkg::ST_CONVERT
                                         && state_reg.cycleCount == 5'h00)
        else $error("Free running did not restart");

    a_sel_frozen: assert property (
        clkEn && state_reg.state == adc_seq_pkg::ST_CONVERT && !lastCycle
        |=> state_reg.liveSel == $past(state_reg.liveSel))
        else $error("Selection changed during conversion");

    a_trig_ignored_busy: assert property (
        clkEn && converterEnable && trigPulse && !riseTick
        && state_reg.state == adc_seq_pkg::ST_CONVERT
        |=> state_reg.cycleCount == $past(state_reg.cycleCount))
        else $error("Trigger disturbed a running conversion");

    a_disabled_idle: assert property (
        clkEn && !converterEnable |=> state_reg.state == adc_seq_pkg::ST_IDLE
                                      && !state_reg.startBit && state_reg.firstConv)
        else $error("Disabled converter not idle");

    a_armed_waits_edge: assert property (
        clkEn && state_reg.state == adc_seq_pkg::ST_ARMED && !riseTick && !trigAccept
        && converterEnable |=> state_reg.state == adc_seq_pkg::ST_ARMED)
        else $error("Conversion began off the converter clock edge");

    a_normal_length: assert property (
        state_reg.state == adc_seq_pkg::ST_CONVERT && !state_reg.firstConv
        |-> state_reg.cycleCount < adc_seq_pkg::NORMAL_CYCLES)
        else $error("Normal conversion ran past its length");

    a_hold_in_conv: assert property (
        state_reg.sampleHold
        |-> state_reg.state == adc_seq_pkg::ST_CONVERT)
        else $error("Sample hold outside a conversion");

    a_hold_one_cycle: assert property (
        clkEn && state_reg.sampleHold
        |=> !state_reg.sampleHold)
        else $error("Sample hold pulse too long");

    a_start_arms: assert property (
        clkEn && converterEnable && startWrite && !trigAccept
        && state_reg.state == adc_seq_pkg::ST_IDLE |=> state_reg.startBit)
        else $error("Start write did not set the start bit");

    a_armed_converts: assert property (
        clkEn && converterEnable && riseTick && state_reg.state == adc_seq_pkg::ST_ARMED
        |=> state_reg.state == adc_seq_pkg::ST_CONVERT && state_reg.cycleCount == '0)
        else $error("Armed start missed the converter clock edge");

    a_trig_starts: assert property (
        clkEn && trigAccept
        |=> state_reg.state == adc_seq_pkg::ST_CONVERT && state_reg.startBit)
        else $error("Accepted trigger did not start a conversion");

    a_trig_resets_clock: assert property (
        clkEn && trigAccept
        |=> u_prescaler.count_reg == '0)
        else $error("Trigger did not reset the prescaler");

    a_off_no_ticks: assert property (
        !converterEnable
        |-> !riseTick && !fallTick)
        else $error("Converter clock ran while disabled");

    a_off_count_zero: assert property (
        clkEn && !converterEnable
        |=> u_prescaler.count_reg == '0)
        else $error("Prescaler not held in reset");

    a_done_clears: assert property (
        clkEn && doneFlagClear && !complete
        |=> !state_reg.doneFlag)
        else $error("Done flag ignored its clear");

    a_done_no_stray: assert property (
        clkEn && !complete && !state_reg.doneFlag
        |=> !state_reg.doneFlag)
        else $error("Done flag set without completion");

    a_result_stable: assert property (
        clkEn && !complete
        |=> state_reg.result == $past(state_reg.result))
        else $error("Result changed without completion");

    a_first_length: assert property (
        state_reg.state == adc_seq_pkg::ST_CONVERT
        |-> state_reg.cycleCount < adc_seq_pkg::FIRST_CYCLES)
        else $error("First conversion ran past its length");

    a_first_once: assert property (
        clkEn && complete
        |=> !state_reg.firstConv)
        else $error("Long conversion repeated");

    a_wake_on_done: assert property (
        clkEn && complete && cpuHalted
        |=> state_reg.wake)
        else $error("Completion did not wake the core");

    a_wake_drops: assert property (
        clkEn && !cpuHalted
        |=> !state_reg.wake)
        else $error("Wake request outlived the halt");

    a_sleep_arms: assert property (
        clkEn && converterEnable && sleepStart && !trigAccept
        && state_reg.state == adc_seq_pkg::ST_IDLE |=> state_reg.state == adc_seq_pkg::ST_ARMED)
        else $error("Halt did not start a conversion");

    a_busy_holds: assert property (
        clkEn && converterEnable && !riseTick && state_reg.state == adc_seq_pkg::ST_CONVERT
        |=> state_reg.state == adc_seq_pkg::ST_CONVERT)
        else $error("Conversion left off the converter clock edge");

    a_chan_tracks: assert property (
        clkEn && state_reg.state != adc_seq_pkg::ST_CONVERT
        |=> state_reg.liveSel.channel == $past(channelSelectBits))
        else $error("Live channel did not track the buffer");

    a_ref_last_cycle: assert property (
        clkEn && lastCycle
        |=> state_reg.liveSel.reference == $past(referenceSelectBits))
        else $error("Reference not updated in the last cycle");

    a_start_until_done: assert property (
        clkEn && converterEnable && state_reg.startBit && !complete
        |=> state_reg.startBit)
        else $error("Start bit dropped before completion");

    a_idle_start_low: assert property (
        state_reg.state == adc_seq_pkg::ST_IDLE
        |-> !state_reg.startBit)
        else $error("Start bit high while idle");

    a_amp_clears_start: assert property (
        clkEn && complete && amplifiedChannel
        |=> !state_reg.startBit && state_reg.state == adc_seq_pkg::ST_IDLE)
        else $error("Amplified conversion kept running");

endmodule // adc_conversion_sequencer

// file: dv/trigger_event_model.sv
module trigger_event_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] flagSet,
    input  wire logic [7:0] flagClr,
    output logic      [7:0] flags
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sticky event flags, set whatever the interrupt enables, cleared by software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags <= 8'h00;
        end else begin
            flags <= (flags & ~flagClr) | flagSet;
        end
    end
endmodule // trigger_event_model

// file: dv/adc_conversion_sequencer_tb.sv
module adc_conversion_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [9:0]              res;
        adc_seq_pkg::selection_s sel;
        logic                    sb;
        logic [15:0]             h2d;
    } note_s;
    logic       clk = 0, rst = 1, clkEn = 1, converterEnable = 0;
    logic       startWrite = 0, autoTriggerEnable = 0, doneFlagClear = 0;
    logic       amplifiedChannel = 0, cpuHalted = 0;
    logic [2:0] triggerSourceSelect = 0, clockPrescaleSelect = 0;
    logic [7:0] triggerSources, flagSet = 0, flagClr = 0;
    logic [4:0] channelSelectBits = 0, liveChannel;
    logic [1:0] referenceSelectBits = 0, liveReference;
    logic [9:0] sarResult = 0, resultData;
    logic       conversionStartBit, conversionDoneFlag, sampleHold, wakeRequest;
    logic       prevDone = 0;
    int         num_errors = 0, checks = 0, cyc = 0, holdCnt = 0;
    note_s      expQ[$];
    note_s      cur;

    adc_conversion_sequencer dut_u (
        .clk, .rst, .clkEn, .converterEnable, .startWrite, .autoTriggerEnable,
        .triggerSourceSelect, .triggerSources, .doneFlagClear, .clockPrescaleSelect,
        .channelSelectBits, .referenceSelectBits, .amplifiedChannel, .cpuHalted,
        .sarResult, .conversionStartBit, .conversionDoneFlag, .resultData,
        .liveChannel, .liveReference, .sampleHold, .wakeRequest
    );
    trigger_event_model src_u (
        .clk, .rst, .flagSet, .flagClr, .flags(triggerSources)
    );

    always #20 clk = ~clk;

    task automatic cmp(string what, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic note(int h2d, logic sb = 1'b0);
        expQ.push_back('{sarResult, '{channelSelectBits, referenceSelectBits}, sb, h2d[15:0]});
    endtask

    task automatic pick;
        channelSelectBits = 5'($urandom);
        referenceSelectBits = 2'($urandom);
        sarResult = 10'($urandom);
    endtask

    task automatic start;
        startWrite = 1;
        tick();
        startWrite = 0;
    endtask

    task automatic waitDone;
        int n;
        n = 0;
        while (conversionDoneFlag !== 1'b1 && n < 9000) begin
            tick();
            n++;
        end
        cmp("done wait", 1, n < 9000);
        doneFlagClear = 1;
        tick();
        doneFlagClear = 0;
    endtask

    task automatic trig(int i);
        int n;
        n = 0;
        flagSet = 8'(1 << i);
        tick();
        flagSet = 0;
        while (sampleHold !== 1'b1 && n < 300) begin
            tick();
            n++;
        end
        cmp("trigger to hold", 1, n >= 18 && n <= 21);
    endtask

    // Result checker: each completion consumes the oldest expectation
    always @(negedge clk) begin
        if (!rst) begin
            holdCnt++;
            if (sampleHold === 1'b1) begin
                holdCnt = 0;
                if (expQ.size() == 0) cmp("stray hold", 0, 1);
                else cmp("live sel", expQ[0].sel, {liveChannel, liveReference});
            end
            if (conversionDoneFlag === 1'b1 && !prevDone) begin
                if (expQ.size() == 0) begin
                    cmp("stray done", 0, 1);
                end else begin
                    cur = expQ.pop_front();
                    cmp("result", cur.res, resultData);
                    cmp("start bit", cur.sb, conversionStartBit);
                    if (cur.h2d != 0) cmp("hold to done", 1,
                        holdCnt >= int'(cur.h2d) - 1 && holdCnt <= int'(cur.h2d) + 1);
                end
            end
            prevDone = conversionDoneFlag === 1'b1;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        void'($urandom(50572));
        repeat (4) @(posedge clk);
        #2;
        rst = 0;
        start();
        tick(40);
        cmp("start bit", 0, conversionStartBit);
        clockPrescaleSelect = 3'h2;
        converterEnable = 1;
        pick();
        note(23 << 2);
        start();
        tick(24);
        channelSelectBits = ~channelSelectBits;
        start();
        waitDone();
        tick();
        cmp("tracked chan", channelSelectBits, liveChannel);
        for (int p = 0; p < 8; p++) begin
            clockPrescaleSelect = p[2:0];
            pick();
            note(19 << p);
            start();
            waitDone();
        end
        clockPrescaleSelect = 3'h2;
        autoTriggerEnable = 1;
        for (int i = 1; i < 8; i++) begin
            triggerSourceSelect = i[2:0];
            pick();
            note(0);
            trig(i);
            flagClr = 8'(1 << i);
            tick();
            flagClr = 0;
            flagSet = 8'(1 << i);
            tick();
            flagSet = 0;
            waitDone();
            tick(60);
            flagSet = 8'(1 << i);
            tick();
            flagSet = 0;
            tick(60);
            flagClr = 8'(1 << i);
            tick();
            flagClr = 0;
        end
        pick();
        note(19 << 2);
        start();
        waitDone();
        triggerSourceSelect = 0;
        pick();
        note(19 << 2, 1);
        note(19 << 2, 1);
        start();
        waitDone();
        channelSelectBits = ~channelSelectBits;
        note(19 << 2);
        waitDone();
        autoTriggerEnable = 0;
        waitDone();
        tick(100);
        autoTriggerEnable = 1;
        amplifiedChannel = 1;
        pick();
        note(19 << 2);
        start();
        waitDone();
        tick(100);
        autoTriggerEnable = 0;
        amplifiedChannel = 0;
        pick();
        note(19 << 2);
        cpuHalted = 1;
        waitDone();
        tick();
        cmp("wake", 1, wakeRequest);
        cpuHalted = 0;
        tick(2);
        cmp("wake", 0, wakeRequest);
        pick();
        start();
        tick(16);
        converterEnable = 0;
        tick(4);
        cmp("start bit", 0, conversionStartBit);
        converterEnable = 1;
        pick();
        note((23 << 2) + 10);
        start();
        tick(150);
        clkEn = 0;
        tick(10);
        cmp("start bit", 1, conversionStartBit);
        clkEn = 1;
        waitDone();
        tick(20);
        summarize();
    end
endmodule // adc_conversion_sequencer_tb
